// *** hw/scr_consts.vh ***
// Constants for the converter control and receiver status register bank.
// Included by bare name by scr_burst_dec and scr_regs_top of the bank; definitions only.
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH

// Register offsets on the byte-wide host port
`define SCR_OFS_SUBCODE_SECONDS    7'h23
`define SCR_OFS_SUBCODE_FRAME      7'h24
`define SCR_OFS_SUBCODE_ZERO_BYTE  7'h25
`define SCR_OFS_SUBCODE_ABS_MIN    7'h26
`define SCR_OFS_SUBCODE_ABS_SEC    7'h27
`define SCR_OFS_SUBCODE_ABS_FRAME  7'h28
`define SCR_OFS_BURST_INFO_HIGH    7'h29
`define SCR_OFS_BURST_INFO_LOW     7'h2A
`define SCR_OFS_BURST_LENGTH_HIGH  7'h2B
`define SCR_OFS_BURST_LENGTH_LOW   7'h2C
`define SCR_OFS_CONV_CONTROL_ONE   7'h2D
`define SCR_OFS_CONV_CONTROL_TWO   7'h2E
`define SCR_OFS_PAGE_SELECT        7'h7F

// Status memory entries: six sub-code bytes then four burst bytes
`define SCR_STAT_ENTRIES           10
`define SCR_STAT_BURST_BASE        4'h6

// Control one fields
`define SCR_C1_INPUT_SEL_LSB       0
`define SCR_C1_REFCLK_SEL_LSB      2
`define SCR_C1_MUTE_BIT            4
`define SCR_C1_TRACK_BIT           6
`define SCR_C1_WRITE_MASK          8'h5F
`define SCR_C1_RESET               8'h00

// Control two fields
`define SCR_C2_PREBUF_LSB          0
`define SCR_C2_DOWNSAMPLE_BIT      2
`define SCR_C2_DEEMPH_LSB          3
`define SCR_C2_AUTO_DEEMPH_BIT     5
`define SCR_C2_WRITE_MASK          8'h3F
`define SCR_C2_RESET               8'h00

// Page selector
`define SCR_PAGE_CONTROL           2'h0
`define SCR_PAGE_RESET             2'h0

// Pre-buffer depth in samples for selector code 00
`define SCR_PREBUF_MAX_SAMPLES     7'h40

// Burst preamble sync words and info word fields
`define SCR_SYNC_WORD_A            16'hF872
`define SCR_SYNC_WORD_B            16'h4E1F
`define SCR_INFO_TYPE_LSB          0
`define SCR_INFO_ERR_BIT           7
`define SCR_INFO_STREAM_LSB        13
`define SCR_TYPE_NULL              5'h00
`define SCR_TYPE_PAUSE             5'h03
`define SCR_TYPE_RSVD_A            5'h02
`define SCR_TYPE_RSVD_B            5'h0A
`define SCR_TYPE_RSVD_FROM         5'h10

`endif

// *** hw/scr_stat_mem.v ***
// Small status memory: one write port, one read port with registered data.
// Assumes the caller keeps addresses below DEPTH; clocked on clock, sync rst.
`timescale 1ns/1ns
module scr_stat_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 10,
  parameter AW    = 4
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output wire [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [WIDTH-1:0] rd_data_ff;

  // Storage array, no reset so it maps to plain memory
  always @(posedge clock) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Registered read; entries hold no value until first swept
  always @(posedge clock) begin
    if (rst) begin
      rd_data_ff <= {WIDTH{1'b0}};
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end

  assign rd_data = rd_data_ff;

endmodule // scr_stat_mem

// *** hw/scr_burst_dec.v ***
// Burst preamble hunter: finds the two sync words, then takes info and length.
// Assumes one receiver word per rx_valid strobe, words in stream order.
`timescale 1ns/1ns
`include "scr_consts.vh"
module scr_burst_dec (
  input  wire        clock,
  input  wire        rst,
  input  wire [15:0] rx_word,
  input  wire        rx_valid,
  output wire [15:0] info_word,
  output wire [15:0] length_word,
  output wire        found
);

  localparam ST_HUNT   = 2'b00;
  localparam ST_SYNC_A = 2'b01;
  localparam ST_SYNC_B = 2'b10;
  localparam ST_INFO   = 2'b11;

  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [15:0] info_ff;
  reg [15:0] length_ff;
  reg        found_ff;

  // Next state on each received word
  always @* begin
    nxt_state = state_ff;
    if (rx_valid) begin
      case (state_ff)
        ST_HUNT: begin
          if (rx_word == `SCR_SYNC_WORD_A) nxt_state = ST_SYNC_A;
        end
        ST_SYNC_A: begin
          if (rx_word == `SCR_SYNC_WORD_B) nxt_state = ST_SYNC_B;
          else if (rx_word != `SCR_SYNC_WORD_A) nxt_state = ST_HUNT;
        end
        ST_SYNC_B: nxt_state = ST_INFO;
        ST_INFO:   nxt_state = ST_HUNT;
        default:   nxt_state = ST_HUNT;
      endcase
    end
  end

  // Capture info then length; pulse once the pair is complete
  always @(posedge clock) begin
    if (rst) begin
      state_ff  <= ST_HUNT;
      info_ff   <= 16'h0000;
      length_ff <= 16'h0000;
      found_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      found_ff <= 1'b0;
      if (rx_valid && state_ff == ST_SYNC_B) begin
        info_ff <= rx_word;
      end
      if (rx_valid && state_ff == ST_INFO) begin
        length_ff <= rx_word;
        found_ff  <= 1'b1;
      end
    end
  end

  assign info_word   = info_ff;
  assign length_word = length_ff;
  assign found       = found_ff;

endmodule // scr_burst_dec

// *** hw/scr_regs_top.v ***
// Control page zero bank: sub-code and burst status, converter control bytes.
// Assumes a host port decoder in front presenting byte reads and writes,
// a sub-code decoder giving bits 32..79 with a strobe, and receiver words.
`timescale 1ns/1ns
`include "scr_consts.vh"
module scr_regs_top #(
  parameter SAMPLE_W = 24
) (
  input  wire                clock,
  input  wire                rst,
  input  wire [6:0]          host_addr,
  input  wire [7:0]          host_wdata,
  input  wire                host_wr,
  input  wire                host_rd,
  output wire [7:0]          host_rdata,
  output wire                host_rvalid,
  input  wire [47:0]         qsub_bits,
  input  wire                qsub_valid,
  input  wire [15:0]         rx_word,
  input  wire                rx_word_valid,
  input  wire [SAMPLE_W-1:0] conv_left_in,
  input  wire [SAMPLE_W-1:0] conv_right_in,
  input  wire                conv_sample_valid,
  input  wire [7:0]          atten_left_in,
  input  wire [7:0]          atten_right_in,
  input  wire [1:0]          auto_deemph_rate_in,
  output wire [1:0]          page_sel,
  output wire [1:0]          conv_input_select,
  output wire [1:0]          conv_refclk_select,
  output wire                soft_mute,
  output wire                atten_track,
  output wire [1:0]          prebuffer_depth_sel,
  output wire [6:0]          prebuffer_samples,
  output wire                direct_downsample_sel,
  output wire [1:0]          manual_deemph_rate,
  output wire                auto_deemph_enable,
  output wire [1:0]          deemph_rate_eff,
  output wire [7:0]          atten_left_eff,
  output wire [7:0]          atten_right_eff,
  output wire [SAMPLE_W-1:0] conv_left_out,
  output wire [SAMPLE_W-1:0] conv_right_out,
  output wire                conv_out_valid,
  output wire                burst_found,
  output wire [4:0]          burst_type,
  output wire                burst_err,
  output wire                burst_type_reserved,
  output wire [2:0]          burst_stream
);

  // Read source selects for the second read stage
  localparam RS_MEM  = 3'h0;
  localparam RS_C1   = 3'h1;
  localparam RS_C2   = 3'h2;
  localparam RS_PAGE = 3'h3;
  localparam RS_ZERO = 3'h4;

  // Control and page state
  reg [7:0]          ctrl_one_ff;
  reg [7:0]          ctrl_two_ff;
  reg [1:0]          page_ff;

  // Status staging and memory write sweep
  reg [47:0]         qsub_stage_ff;
  reg                sweep_pend_ff;
  reg                sweep_act_ff;
  reg [3:0]          sweep_idx_ff;
  reg [7:0]          sweep_data;
  wire [47:0]        qsub_rev;
  wire [15:0]        info_word;
  wire [15:0]        length_word;
  wire               found;
  wire [7:0]         mem_rd_data;
  wire [6:0]         mem_ofs;
  wire               stat_hit;

  // Host read pipeline
  reg                rd_pend_ff;
  reg [2:0]          rd_src_ff;
  reg [2:0]          nxt_rd_src;
  reg [7:0]          host_rdata_ff;
  reg                host_rvalid_ff;

  // Registered control outputs
  reg [6:0]          prebuf_samples_ff;
  reg [1:0]          deemph_eff_ff;
  reg [7:0]          atten_left_ff;
  reg [7:0]          atten_right_ff;
  reg [SAMPLE_W-1:0] left_out_ff;
  reg [SAMPLE_W-1:0] right_out_ff;
  reg                out_valid_ff;
  reg                burst_found_ff;
  reg [4:0]          burst_type_ff;
  reg                burst_err_ff;
  reg                burst_rsvd_ff;
  reg [2:0]          burst_stream_ff;
  reg                nxt_rsvd;

  wire               page_zero;
  wire               wr_c1;
  wire               wr_c2;
  wire               wr_page;

  // Page zero gate for every bank register except the page selector
  assign page_zero = (page_ff == `SCR_PAGE_CONTROL);
  assign wr_c1     = host_wr && page_zero && (host_addr == `SCR_OFS_CONV_CONTROL_ONE);
  assign wr_c2     = host_wr && page_zero && (host_addr == `SCR_OFS_CONV_CONTROL_TWO);
  assign wr_page   = host_wr && (host_addr == `SCR_OFS_PAGE_SELECT);

  // Control bytes; reserved bits never store
  always @(posedge clock) begin
    if (rst) begin
      ctrl_one_ff <= `SCR_C1_RESET;
      ctrl_two_ff <= `SCR_C2_RESET;
      page_ff     <= `SCR_PAGE_RESET;
    end else begin
      if (wr_c1) begin
        ctrl_one_ff <= host_wdata & `SCR_C1_WRITE_MASK;
      end
      if (wr_c2) begin
        ctrl_two_ff <= host_wdata & `SCR_C2_WRITE_MASK;
      end
      if (wr_page) begin
        page_ff <= host_wdata[1:0];
      end
    end
  end

  // Sub-code bytes put lowest-numbered bit into register bit 7
  genvar gi;
  generate
    for (gi = 0; gi < 48; gi = gi + 1) begin : g_qrev
      assign qsub_rev[(gi / 8) * 8 + 7 - (gi % 8)] = qsub_stage_ff[gi];
    end
  endgenerate

  // Receiver burst preamble hunter
  scr_burst_dec u_burst (
    .clock       (clock),
    .rst         (rst),
    .rx_word     (rx_word),
    .rx_valid    (rx_word_valid),
    .info_word   (info_word),
    .length_word (length_word),
    .found       (found)
  );

  // Byte written at each sweep index
  always @* begin
    case (sweep_idx_ff)
      4'h0:    sweep_data = qsub_rev[7:0];
      4'h1:    sweep_data = qsub_rev[15:8];
      4'h2:    sweep_data = qsub_rev[23:16];
      4'h3:    sweep_data = qsub_rev[31:24];
      4'h4:    sweep_data = qsub_rev[39:32];
      4'h5:    sweep_data = qsub_rev[47:40];
      4'h6:    sweep_data = info_word[15:8];
      4'h7:    sweep_data = info_word[7:0];
      4'h8:    sweep_data = length_word[15:8];
      4'h9:    sweep_data = length_word[7:0];
      default: sweep_data = 8'h00;
    endcase
  end

  // Stage new sub-code and sweep all entries into memory.
  // A new event during a sweep sets pending again, so it is never lost.
  always @(posedge clock) begin
    if (rst) begin
      qsub_stage_ff <= 48'h000000000000;
      sweep_pend_ff <= 1'b0;
      sweep_act_ff  <= 1'b0;
      sweep_idx_ff  <= 4'h0;
    end else begin
      if (qsub_valid) begin
        qsub_stage_ff <= qsub_bits;
      end
      if (qsub_valid || found) begin
        sweep_pend_ff <= 1'b1;
      end else if (!sweep_act_ff && sweep_pend_ff) begin
        sweep_pend_ff <= 1'b0;
      end
      if (!sweep_act_ff) begin
        sweep_act_ff <= sweep_pend_ff;
        sweep_idx_ff <= 4'h0;
      end else if (sweep_idx_ff == `SCR_STAT_ENTRIES - 1) begin
        sweep_act_ff <= 1'b0;
        sweep_idx_ff <= 4'h0;
      end else begin
        sweep_idx_ff <= sweep_idx_ff + 4'h1;
      end
    end
  end

  // Status window decode for host reads
  assign mem_ofs  = host_addr - `SCR_OFS_SUBCODE_SECONDS;
  assign stat_hit = (host_addr >= `SCR_OFS_SUBCODE_SECONDS) && (host_addr <= `SCR_OFS_BURST_LENGTH_LOW);

  scr_stat_mem #(
    .WIDTH (8),
    .DEPTH (`SCR_STAT_ENTRIES),
    .AW    (4)
  ) u_mem (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (sweep_act_ff),
    .wr_addr (sweep_idx_ff),
    .wr_data (sweep_data),
    .rd_addr (mem_ofs[3:0]),
    .rd_data (mem_rd_data)
  );

  // Read source for the addressed register
  always @* begin
    nxt_rd_src = RS_ZERO;
    if (host_addr == `SCR_OFS_PAGE_SELECT) begin
      nxt_rd_src = RS_PAGE;
    end else if (page_zero) begin
      if (stat_hit) begin
        nxt_rd_src = RS_MEM;
      end else if (host_addr == `SCR_OFS_CONV_CONTROL_ONE) begin
        nxt_rd_src = RS_C1;
      end else if (host_addr == `SCR_OFS_CONV_CONTROL_TWO) begin
        nxt_rd_src = RS_C2;
      end
    end
  end

  // Two-stage read: memory read, then data and valid out
  always @(posedge clock) begin
    if (rst) begin
      rd_pend_ff     <= 1'b0;
      rd_src_ff      <= RS_ZERO;
      host_rdata_ff  <= 8'h00;
      host_rvalid_ff <= 1'b0;
    end else begin
      rd_pend_ff     <= host_rd;
      rd_src_ff      <= nxt_rd_src;
      host_rvalid_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        case (rd_src_ff)
          RS_MEM:  host_rdata_ff <= mem_rd_data;
          RS_C1:   host_rdata_ff <= ctrl_one_ff;
          RS_C2:   host_rdata_ff <= ctrl_two_ff;
          RS_PAGE: host_rdata_ff <= {6'h00, page_ff};
          default: host_rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // Payload type reserved codes
  always @* begin
    nxt_rsvd = (info_word[4:0] == `SCR_TYPE_RSVD_A) || (info_word[4:0] == `SCR_TYPE_RSVD_B) ||
               (info_word[4:0] >= `SCR_TYPE_RSVD_FROM);
  end

  // Decoded burst fields, updated when a complete preamble arrives
  always @(posedge clock) begin
    if (rst) begin
      burst_found_ff  <= 1'b0;
      burst_type_ff   <= `SCR_TYPE_NULL;
      burst_err_ff    <= 1'b0;
      burst_rsvd_ff   <= 1'b0;
      burst_stream_ff <= 3'h0;
    end else begin
      burst_found_ff <= found;
      if (found) begin
        burst_type_ff   <= info_word[`SCR_INFO_TYPE_LSB +: 5];
        burst_err_ff    <= info_word[`SCR_INFO_ERR_BIT];
        burst_rsvd_ff   <= nxt_rsvd;
        burst_stream_ff <= info_word[`SCR_INFO_STREAM_LSB +: 3];
      end
    end
  end

  // Derived converter settings
  always @(posedge clock) begin
    if (rst) begin
      prebuf_samples_ff <= `SCR_PREBUF_MAX_SAMPLES;
      deemph_eff_ff     <= 2'h0;
      atten_left_ff     <= 8'h00;
      atten_right_ff    <= 8'h00;
    end else begin
      // 64 halved per step of the selector
      prebuf_samples_ff <= `SCR_PREBUF_MAX_SAMPLES >> ctrl_two_ff[`SCR_C2_PREBUF_LSB +: 2];
      if (ctrl_two_ff[`SCR_C2_AUTO_DEEMPH_BIT]) begin
        deemph_eff_ff <= auto_deemph_rate_in;
      end else begin
        deemph_eff_ff <= ctrl_two_ff[`SCR_C2_DEEMPH_LSB +: 2];
      end
      // Attenuation bytes in half-decibel steps
      atten_left_ff <= atten_left_in;
      if (ctrl_one_ff[`SCR_C1_TRACK_BIT]) begin
        atten_right_ff <= atten_left_in;
      end else begin
        atten_right_ff <= atten_right_in;
      end
    end
  end

  // Output sample gate for soft mute
  always @(posedge clock) begin
    if (rst) begin
      left_out_ff  <= {SAMPLE_W{1'b0}};
      right_out_ff <= {SAMPLE_W{1'b0}};
      out_valid_ff <= 1'b0;
    end else begin
      out_valid_ff <= conv_sample_valid;
      if (conv_sample_valid) begin
        if (ctrl_one_ff[`SCR_C1_MUTE_BIT]) begin
          left_out_ff  <= {SAMPLE_W{1'b0}};
          right_out_ff <= {SAMPLE_W{1'b0}};
        end else begin
          left_out_ff  <= conv_left_in;
          right_out_ff <= conv_right_in;
        end
      end
    end
  end

  // Outputs taken straight from the control, status and read flip-flops
  assign host_rdata            = host_rdata_ff;
  assign host_rvalid           = host_rvalid_ff;
  assign page_sel              = page_ff;
  assign conv_input_select     = ctrl_one_ff[`SCR_C1_INPUT_SEL_LSB +: 2];
  assign conv_refclk_select    = ctrl_one_ff[`SCR_C1_REFCLK_SEL_LSB +: 2];
  assign soft_mute             = ctrl_one_ff[`SCR_C1_MUTE_BIT];
  assign atten_track           = ctrl_one_ff[`SCR_C1_TRACK_BIT];
  assign prebuffer_depth_sel   = ctrl_two_ff[`SCR_C2_PREBUF_LSB +: 2];
  assign prebuffer_samples     = prebuf_samples_ff;
  assign direct_downsample_sel = ctrl_two_ff[`SCR_C2_DOWNSAMPLE_BIT];
  assign manual_deemph_rate    = ctrl_two_ff[`SCR_C2_DEEMPH_LSB +: 2];
  assign auto_deemph_enable    = ctrl_two_ff[`SCR_C2_AUTO_DEEMPH_BIT];
  assign deemph_rate_eff       = deemph_eff_ff;
  assign atten_left_eff        = atten_left_ff;
  assign atten_right_eff       = atten_right_ff;
  assign conv_left_out         = left_out_ff;
  assign conv_right_out        = right_out_ff;
  assign conv_out_valid        = out_valid_ff;
  assign burst_found           = burst_found_ff;
  assign burst_type            = burst_type_ff;
  assign burst_err             = burst_err_ff;
  assign burst_type_reserved   = burst_rsvd_ff;
  assign burst_stream          = burst_stream_ff;

endmodule // scr_regs_top

// *** bench/scr_regs_properties.sv ***
// Concurrent checks on the page zero control and status bank.
// Bound to scr_regs_top below; one clock, synchronous active high reset.
`timescale 1ns/1ns
module scr_regs_props #(
  parameter SAMPLE_W = 24
) (
  input wire                clock,
  input wire                rst,
  input wire [6:0]          host_addr,
  input wire [7:0]          host_wdata,
  input wire                host_wr,
  input wire                host_rd,
  input wire [7:0]          host_rdata,
  input wire                host_rvalid,
  input wire [15:0]         rx_word,
  input wire                rx_word_valid,
  input wire [SAMPLE_W-1:0] conv_left_in,
  input wire [SAMPLE_W-1:0] conv_right_in,
  input wire                conv_sample_valid,
  input wire [7:0]          atten_left_in,
  input wire [1:0]          auto_deemph_rate_in,
  input wire [1:0]          page_sel,
  input wire [1:0]          conv_input_select,
  input wire [1:0]          conv_refclk_select,
  input wire                soft_mute,
  input wire                atten_track,
  input wire [1:0]          prebuffer_depth_sel,
  input wire [6:0]          prebuffer_samples,
  input wire [1:0]          manual_deemph_rate,
  input wire                auto_deemph_enable,
  input wire [1:0]          deemph_rate_eff,
  input wire [7:0]          atten_right_eff,
  input wire [SAMPLE_W-1:0] conv_left_out,
  input wire [SAMPLE_W-1:0] conv_right_out,
  input wire                conv_out_valid,
  input wire                burst_found,
  input wire [4:0]          burst_type,
  input wire                burst_err,
  input wire                burst_type_reserved
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Helper views of write data and receiver word fields
  wire       c1_hit  = host_wr && host_addr == 7'h2D && page_sel == 2'h0;
  wire [5:0] c1_wval = {host_wdata[6], host_wdata[4:0]};
  wire [4:0] rx_type = rx_word[4:0];
  wire       rx_err  = rx_word[7];

  AST_RD_LAT: assert property (host_rd |-> ##2 host_rvalid)
    else $error("read answer late");
  AST_RD_PAGE: assert property (host_rd && page_sel != 2'h0 && host_addr != 7'h7F |-> ##2 host_rdata == 8'h00)
    else $error("read off page zero not zero");
  AST_C1_WR: assert property (c1_hit |=> {atten_track, soft_mute, conv_refclk_select, conv_input_select} == $past(c1_wval))
    else $error("control one write not taken");
  AST_C1_HOLD: assert property (!c1_hit |=> $stable({atten_track, soft_mute, conv_refclk_select, conv_input_select}))
    else $error("control one changed without write");
  AST_PREBUF: assert property ($stable(prebuffer_depth_sel) |-> prebuffer_samples == (7'h40 >> prebuffer_depth_sel))
    else $error("pre-buffer depth wrong");
  AST_MUTE: assert property (conv_sample_valid && soft_mute |=> conv_out_valid && conv_left_out == 0 && conv_right_out == 0)
    else $error("muted sample not zero");
  AST_PASS: assert property (conv_sample_valid && !soft_mute |=> conv_out_valid && conv_left_out == $past(conv_left_in)
    && conv_right_out == $past(conv_right_in))
    else $error("sample not passed");
  AST_TRACK: assert property (atten_track ##1 atten_track |-> atten_right_eff == $past(atten_left_in))
    else $error("right does not follow left");
  AST_DEEMPH: assert property (1'b1 |=> deemph_rate_eff ==
    ($past(auto_deemph_enable) ? $past(auto_deemph_rate_in) : $past(manual_deemph_rate)))
    else $error("de-emphasis rate wrong");
  AST_BTYPE: assert property (burst_found |-> burst_type_reserved ==
    (burst_type == 5'h02 || burst_type == 5'h0A || burst_type[4]))
    else $error("reserved type flag wrong");
  AST_SYNC: assert property (rx_word_valid && rx_word == 16'hF872 ##1 rx_word_valid && rx_word == 16'h4E1F
    ##1 rx_word_valid ##1 rx_word_valid |-> ##2 burst_found && burst_type == $past(rx_type, 3) && burst_err == $past(rx_err, 3))
    else $error("burst not found after sync");
  AST_FOUND_CAUSE: assert property (burst_found |-> $past(rx_word_valid, 2))
    else $error("burst found without word");
endmodule // scr_regs_props

bind scr_regs_top scr_regs_props #(.SAMPLE_W(SAMPLE_W)) chk_u (
  .clock, .rst, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata, .host_rvalid, .rx_word, .rx_word_valid,
  .conv_left_in, .conv_right_in, .conv_sample_valid, .atten_left_in, .auto_deemph_rate_in, .page_sel,
  .conv_input_select, .conv_refclk_select, .soft_mute, .atten_track, .prebuffer_depth_sel, .prebuffer_samples,
  .manual_deemph_rate, .auto_deemph_enable, .deemph_rate_eff, .atten_right_eff, .conv_left_out, .conv_right_out,
  .conv_out_valid, .burst_found, .burst_type, .burst_err, .burst_type_reserved
);

// *** bench/scr_regs_top_tb.sv ***
// Self-checking bench for the page zero control and status bank.
// Drives all inputs of scr_regs_top at the rising edge; byte model in the bench.
`timescale 1ns/1ns
module scr_regs_top_tb;
  reg         clock, rst, host_wr, host_rd, qsub_valid, rx_word_valid, conv_sample_valid;
  reg  [6:0]  host_addr;
  reg  [7:0]  host_wdata, atten_left_in, atten_right_in, c1, c2;
  reg  [47:0] qsub_bits;
  reg  [15:0] rx_word;
  reg  [23:0] conv_left_in, conv_right_in;
  reg  [1:0]  auto_deemph_rate_in, page;
  reg  [7:0]  stat [0:9];
  reg  [31:0] r;
  reg  [63:0] q;
  integer     bad_count, num_checks, seed, cyc, i, a;
  wire [7:0]  host_rdata, atten_left_eff, atten_right_eff;
  wire [1:0]  page_sel, conv_input_select, conv_refclk_select, prebuffer_depth_sel, manual_deemph_rate, deemph_rate_eff;
  wire        host_rvalid, soft_mute, atten_track, direct_downsample_sel, auto_deemph_enable, conv_out_valid;
  wire        burst_found, burst_err, burst_type_reserved;
  wire [6:0]  prebuffer_samples;
  wire [23:0] conv_left_out, conv_right_out;
  wire [4:0]  burst_type;
  wire [2:0]  burst_stream;

  scr_regs_top dut_u (.*);

  // Compare one result and count it
  task chk(input string what, input [47:0] exp, input [47:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask

  // Report counts and end the run
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  // Model of what a read returns
  function [7:0] exp_rd(input [6:0] ad);
    begin
      if (ad == 7'h7F) exp_rd = {6'h00, page};
      else if (page != 2'h0) exp_rd = 8'h00;
      else if (ad >= 7'h23 && ad <= 7'h2C) exp_rd = stat[ad - 7'h23];
      else if (ad == 7'h2D) exp_rd = c1;
      else if (ad == 7'h2E) exp_rd = c2;
      else exp_rd = 8'h00;
    end
  endfunction

  // Host write, model follows
  task wr(input [6:0] ad, input [7:0] d);
    begin
      @(posedge clock);
      host_addr <= ad;
      host_wdata <= d;
      host_wr <= 1'b1;
      @(posedge clock);
      host_wr <= 1'b0;
      if (ad == 7'h7F) page = d[1:0];
      else if (page == 2'h0 && ad == 7'h2D) c1 = d & 8'h5F;
      else if (page == 2'h0 && ad == 7'h2E) c2 = d & 8'h3F;
    end
  endtask

  // Host read, answer two cycles after the strobe edge
  task rd(input [6:0] ad);
    begin
      @(posedge clock);
      host_addr <= ad;
      host_rd <= 1'b1;
      @(posedge clock);
      host_rd <= 1'b0;
      @(posedge clock);
      #1;
      chk("rvalid", 1, host_rvalid);
      chk("rdata", exp_rd(ad), host_rdata);
    end
  endtask

  // Receiver words back to back; a bad first word must not sync
  task burst(input [15:0] info, input [15:0] len, input good);
    begin
      @(posedge clock);
      rx_word_valid <= 1'b1;
      rx_word <= good ? 16'hF872 : 16'hF873;
      @(posedge clock);
      rx_word <= 16'h4E1F;
      @(posedge clock);
      rx_word <= info;
      @(posedge clock);
      rx_word <= len;
      @(posedge clock);
      rx_word_valid <= 1'b0;
      rx_word <= ~len;
      @(posedge clock);
      #1;
      chk("found", good, burst_found);
      if (good) begin
        chk("type", info[4:0], burst_type);
        chk("rsvd", info[4:0] == 2 || info[4:0] == 10 || info[4:0] > 15, burst_type_reserved);
        chk("err", info[7], burst_err);
        chk("stream", info[15:13], burst_stream);
        {stat[6], stat[7], stat[8], stat[9]} = {info, len};
      end
      repeat (14) @(posedge clock);
      for (a = 7'h29; a <= 7'h2C; a = a + 1) rd(a[6:0]);
    end
  endtask

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end

  // Main sequence
  initial begin
    {rst, host_wr, host_rd, qsub_valid, rx_word_valid, conv_sample_valid} = 6'h20;
    {host_addr, host_wdata, qsub_bits, rx_word} = 0;
    {conv_left_in, conv_right_in, atten_left_in, atten_right_in, auto_deemph_rate_in} = 0;
    {c1, c2, page} = 0;
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    seed = 32'h04D8135E;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("prebuf", 7'h40, prebuffer_samples);
    rd(7'h2D);
    rd(7'h2E);
    rd(7'h7F);
    $display("end of reset test");
    for (i = 0; i < 4; i = i + 1) begin
      q = {$random(seed), $random(seed)};
      @(posedge clock);
      qsub_bits <= q[47:0];
      qsub_valid <= 1'b1;
      @(posedge clock);
      qsub_valid <= 1'b0;
      for (a = 0; a < 48; a = a + 1) stat[a / 8][7 - a % 8] = q[a];
      repeat (14) @(posedge clock);
      for (a = 7'h23; a <= 7'h28; a = a + 1) rd(a[6:0]);
    end
    $display("end of sub-code test");
    for (i = 0; i < 32; i = i + 1) begin
      r = $random(seed);
      burst({r[15:8], r[7], 2'b00, i[4:0]}, r[31:16], 1'b1);
    end
    burst(16'h0005, 16'h1234, 1'b0);
    $display("end of burst test");
    for (i = 0; i < 24; i = i + 1) begin
      r = $random(seed);
      wr(7'h2D, r[7:0]);
      wr(7'h2E, r[15:8]);
      @(posedge clock);
      conv_left_in <= r[23:0];
      conv_right_in <= r[31:8];
      atten_left_in <= r[23:16];
      atten_right_in <= r[31:24];
      auto_deemph_rate_in <= r[25:24];
      conv_sample_valid <= 1'b1;
      @(posedge clock);
      conv_sample_valid <= 1'b0;
      #1;
      chk("insel", c1[1:0], conv_input_select);
      chk("refclk", c1[3:2], conv_refclk_select);
      chk("mute", c1[4], soft_mute);
      chk("track", c1[6], atten_track);
      chk("depth", c2[1:0], prebuffer_depth_sel);
      chk("samples", 64 >> c2[1:0], prebuffer_samples);
      chk("downs", c2[2], direct_downsample_sel);
      chk("manual", c2[4:3], manual_deemph_rate);
      chk("auto", c2[5], auto_deemph_enable);
      chk("deemph", c2[5] ? r[25:24] : c2[4:3], deemph_rate_eff);
      chk("outv", 1, conv_out_valid);
      chk("left", c1[4] ? 24'h0 : r[23:0], conv_left_out);
      chk("right", c1[4] ? 24'h0 : r[31:8], conv_right_out);
      chk("attl", r[23:16], atten_left_eff);
      chk("attr", c1[6] ? r[23:16] : r[31:24], atten_right_eff);
      rd(7'h2D);
      rd(7'h2E);
    end
    $display("end of control test");
    wr(7'h7F, 8'h02);
    rd(7'h7F);
    chk("page", page, page_sel);
    rd(7'h2D);
    rd(7'h29);
    wr(7'h2D, 8'h55);
    wr(7'h7F, 8'h00);
    rd(7'h2D);
    wr(7'h23, 8'hA5);
    rd(7'h23);
    rd(7'h40);
    $display("end of page test");
    complete_run;
  end
endmodule // scr_regs_top_tb
